// File: design/drp_reset_pins.sv
// dual subsystem reset pins: open-drain drive, pin sync, vector fetch, boot latch
// assumes the pads resolve the wire from the enables and an internal pullup
`timescale 1ns/1ps
module drp_reset_pins
  import drp_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = WDG_PULSE_CYCLES
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              dig_por_i,
  input  wire logic              ana_por_i,
  input  wire logic              wdg_rst_i,
  input  wire logic              digital_reset_pin_i,
  output logic                   digital_reset_pin_o,
  output logic                   digital_reset_pin_oe_n_o,
  input  wire logic              analog_reset_pin_i,
  output logic                   analog_reset_pin_o,
  output logic                   analog_reset_pin_oe_n_o,
  input  wire logic [BOOT_W-1:0] boot_sel_i,
  input  wire logic [31:0]       master_vec_data_i,
  input  wire logic [31:0]       control_vec_data_i,
  output logic [31:0]            master_vec_addr_o,
  output logic [21:0]            control_vec_addr_o,
  output logic [31:0]            master_pc_o,
  output logic [31:0]            control_pc_o,
  output logic                   dig_rst_n_o,
  output logic                   ana_rst_n_o,
  output logic                   master_run_o,
  output logic                   control_run_o,
  output logic [BOOT_W-1:0]      boot_mode_o,
  output logic                   boot_valid_o
);

  // ==========================================================================
  // synchronisers
  logic [1:0] dpin_s_r, dpin_s_nxt, apin_s_r, apin_s_nxt;
  logic [BOOT_W-1:0] boot_s1_r, boot_s2_r, boot_s1_nxt, boot_s2_nxt;

  always_comb begin
    dpin_s_nxt  = {dpin_s_r[0], digital_reset_pin_i};  // see (R12)
    apin_s_nxt  = {apin_s_r[0], analog_reset_pin_i};   // see (R12)
    boot_s1_nxt = boot_sel_i;
    boot_s2_nxt = boot_s1_r;
    if (!rst_n_i) begin
      dpin_s_nxt  = 2'h0;
      apin_s_nxt  = 2'h0;
      boot_s1_nxt = BOOT_RESET;
      boot_s2_nxt = BOOT_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    dpin_s_r  <= dpin_s_nxt;
    apin_s_r  <= apin_s_nxt;
    boot_s1_r <= boot_s1_nxt;
    boot_s2_r <= boot_s2_nxt;
  end

  wire logic dpin_low = ~dpin_s_r[1];
  wire logic apin_low = ~apin_s_r[1];

  // ==========================================================================
  // digital and analog pin drive
  drp_state_t       state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             dpull_r, dpull_nxt, apull_r, apull_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      DRP_IDLE: begin
        if (dig_por_i) begin
          state_nxt = DRP_POR;
        end else if (wdg_rst_i) begin
          state_nxt = DRP_WDG;
          cnt_nxt   = CNT_W'(PULSE_CYCLES - 1);  // see (R2)
        end
      end
      DRP_WDG: begin
        if (dig_por_i) begin
          state_nxt = DRP_POR;
        end else if (cnt_r == '0) begin
          state_nxt = DRP_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      DRP_POR: begin
        if (!dig_por_i) begin
          state_nxt = DRP_IDLE;
        end
      end
      default: state_nxt = DRP_IDLE;
    endcase
    // pull low while por stands or a watchdog pulse runs
    dpull_nxt = dig_por_i || (state_nxt != DRP_IDLE);  // see (R1) see (R2)
    apull_nxt = ana_por_i;                             // see (R9)
    if (!rst_n_i) begin
      state_nxt = DRP_POR;
      cnt_nxt   = '0;
      dpull_nxt = 1'b1;
      apull_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    state_r <= state_nxt;
    cnt_r   <= cnt_nxt;
    dpull_r <= dpull_nxt;
    apull_r <= apull_nxt;
  end

  // ==========================================================================
  // internal resets, vector load, boot latch
  logic        drst_r, drst_nxt, arst_r, arst_nxt;
  logic        mrun_r, mrun_nxt, crun_r, crun_nxt;
  logic [31:0] mpc_r, mpc_nxt, cpc_r, cpc_nxt;
  logic [BOOT_W-1:0] boot_r, boot_nxt;
  logic        bval_r, bval_nxt;

  always_comb begin
    // external pull on either pin is seen through the synchroniser
    drst_nxt = dpull_r || dpin_low || dig_por_i;    // see (R4) see (R12) see (R3)
    arst_nxt = apull_r || apin_low || ana_por_i;    // see (R10) see (R12)
    mpc_nxt  = mpc_r;
    cpc_nxt  = cpc_r;
    boot_nxt = boot_r;
    bval_nxt = bval_r;
    if (drst_r) begin
      mpc_nxt  = master_vec_data_i;                 // see (R5)
      cpc_nxt  = control_vec_data_i;                // see (R6)
      bval_nxt = 1'b0;
    end else if (!bval_r) begin
      boot_nxt = boot_s2_r;                         // see (R11)
      bval_nxt = 1'b1;
    end
    // run only from one cycle after the pc first holds its last loaded vector
    mrun_nxt = !drst_r && !drst_nxt;                // see (R7) see (R4)
    crun_nxt = !drst_r && !drst_nxt;                // see (R7)
    if (!rst_n_i) begin
      drst_nxt = 1'b1;
      arst_nxt = 1'b1;
      mrun_nxt = 1'b0;
      crun_nxt = 1'b0;
      mpc_nxt  = '0;
      cpc_nxt  = '0;
      boot_nxt = BOOT_RESET;
      bval_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    drst_r <= drst_nxt;
    arst_r <= arst_nxt;
    mrun_r <= mrun_nxt;
    crun_r <= crun_nxt;
    mpc_r  <= mpc_nxt;
    cpc_r  <= cpc_nxt;
    boot_r <= boot_nxt;
    bval_r <= bval_nxt;
  end

  // ==========================================================================
  // outputs: pins never drive high, enable low means pulling
  assign digital_reset_pin_o      = 1'b0;      // see (R8)
  assign analog_reset_pin_o       = 1'b0;      // see (R8)
  assign digital_reset_pin_oe_n_o = ~dpull_r;  // see (R8)
  assign analog_reset_pin_oe_n_o  = ~apull_r;  // see (R8)
  assign master_vec_addr_o        = MASTER_VECTOR_ADDR;
  assign control_vec_addr_o       = CONTROL_VECTOR_ADDR;
  assign master_pc_o              = mpc_r;
  assign control_pc_o             = cpc_r;
  assign dig_rst_n_o              = ~drst_r;
  assign ana_rst_n_o              = ~arst_r;
  assign master_run_o             = mrun_r;
  assign control_run_o            = crun_r;
  assign boot_mode_o              = boot_r;
  assign boot_valid_o             = bval_r;

  // ==========================================================================
  // checks
  logic [CNT_W:0] low_cnt_r;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !dpull_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != '1) begin
      low_cnt_r <= low_cnt_r + (CNT_W+1)'(1);
    end
  end

  property p_por_pull;
    @(posedge clock_i) disable iff (!rst_n_i)
      dig_por_i |=> !digital_reset_pin_oe_n_o;
  endproperty
  a_por_pull: assert property (p_por_pull) else $error("por did not pull pin"); // see (R1)

  property p_wdg_len;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == DRP_WDG && cnt_r == '0 && !dig_por_i) |=>
        (digital_reset_pin_oe_n_o && low_cnt_r == (CNT_W+1)'(PULSE_CYCLES));
  endproperty
  a_wdg_len: assert property (p_wdg_len) else $error("watchdog pulse length wrong"); // see (R2)

  property p_wdg_start;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == DRP_IDLE && wdg_rst_i && !dig_por_i) |=> !digital_reset_pin_oe_n_o [*8];
  endproperty
  a_wdg_start: assert property (p_wdg_start) else $error("watchdog pulse not held"); // see (R2)

  property p_halt;
    @(posedge clock_i) disable iff (!rst_n_i)
      !dig_rst_n_o |-> (!master_run_o && !control_run_o);
  endproperty
  a_halt: assert property (p_halt) else $error("cpu runs during reset"); // see (R4)

  property p_mvec;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!dig_rst_n_o) |=> (master_pc_o == $past(master_vec_data_i));
  endproperty
  a_mvec: assert property (p_mvec) else $error("master pc not loaded"); // see (R5)

  property p_cvec;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!dig_rst_n_o) |=> (control_pc_o == $past(control_vec_data_i));
  endproperty
  a_cvec: assert property (p_cvec) else $error("control pc not loaded"); // see (R6)

  property p_run_stable;
    @(posedge clock_i) disable iff (!rst_n_i)
      master_run_o |-> $stable(master_pc_o);
  endproperty
  a_run_stable: assert property (p_run_stable) else $error("pc moved after release"); // see (R7)

  property p_never_high;
    @(posedge clock_i) disable iff (!rst_n_i)
      !digital_reset_pin_o && !analog_reset_pin_o;
  endproperty
  a_never_high: assert property (p_never_high) else $error("pin driven high"); // see (R8)

  property p_ana_por;
    @(posedge clock_i) disable iff (!rst_n_i)
      ana_por_i |=> (!analog_reset_pin_oe_n_o && !ana_rst_n_o);
  endproperty
  a_ana_por: assert property (p_ana_por) else $error("analog por not applied"); // see (R9)

  property p_ana_ext;
    @(posedge clock_i) disable iff (!rst_n_i)
      !analog_reset_pin_i [*3] |=> !ana_rst_n_o;
  endproperty
  a_ana_ext: assert property (p_ana_ext) else $error("analog pin low ignored"); // see (R10)

  property p_dig_ext;
    @(posedge clock_i) disable iff (!rst_n_i)
      !digital_reset_pin_i [*3] |=> !dig_rst_n_o;
  endproperty
  a_dig_ext: assert property (p_dig_ext) else $error("digital pin low ignored"); // see (R12)

  property p_boot;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(boot_valid_o) |-> (boot_mode_o == $past(boot_s2_r));
  endproperty
  a_boot: assert property (p_boot) else $error("boot mode not latched"); // see (R11)

  // a running pulse is never restarted or cut short by a new request
  property p_wdg_refuse;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == DRP_WDG && cnt_r != '0 && !dig_por_i) |=> (state_r == DRP_WDG);
  endproperty
  a_wdg_refuse: assert property (p_wdg_refuse) else $error("watchdog pulse cut"); // see (R2)

  property p_dig_release;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == DRP_IDLE && !dig_por_i && !wdg_rst_i) |=> digital_reset_pin_oe_n_o;
  endproperty
  a_dig_release: assert property (p_dig_release) else $error("digital pin held"); // see (R8)

  property p_ana_release;
    @(posedge clock_i) disable iff (!rst_n_i)
      !ana_por_i |=> analog_reset_pin_oe_n_o;
  endproperty
  a_ana_release: assert property (p_ana_release) else $error("analog pin held"); // see (R8)

  property p_dig_int;
    @(posedge clock_i) disable iff (!rst_n_i)
      !digital_reset_pin_oe_n_o |=> !dig_rst_n_o;
  endproperty
  a_dig_int: assert property (p_dig_int) else $error("own pull not applied"); // see (R4)

  property p_ana_int;
    @(posedge clock_i) disable iff (!rst_n_i)
      !analog_reset_pin_oe_n_o |=> !ana_rst_n_o;
  endproperty
  a_ana_int: assert property (p_ana_int) else $error("analog pull not applied"); // see (R10)

  property p_boot_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      (boot_valid_o && $past(boot_valid_o)) |-> $stable(boot_mode_o);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot mode moved"); // see (R11)

  property p_crun_stable;
    @(posedge clock_i) disable iff (!rst_n_i)
      control_run_o |-> $stable(control_pc_o);
  endproperty
  a_crun_stable: assert property (p_crun_stable) else $error("control pc moved"); // see (R7)

endmodule

// File: inc/drp_pkg.sv
// package for the dual reset pin block: timing counts, vectors, state codes
// assumes one oscillator-rate clock and open-drain pads outside the block
//
// Notes on behaviour
// (R1) power-on reset active pulls the digital reset pin low
// (R2) watchdog reset drives digital reset pin low for exactly 512 oscillator cycles
// (R3) outside party may pull the digital reset pin low, open-drain only
// (R4) any asserted device reset halts execution in the whole digital subsystem
// (R5) master cpu program counter loads from word at 0x00000004 during reset
// (R6) control cpu program counter loads from word at 0x3FFFC0 during reset
// (R7) after release each cpu fetches from its loaded program counter
// (R8) both pins only pull low; released they float high via pullup
// (R9) analog power-on reset active pulls the analog reset pin low
// (R10) any analog reset, including external pull, resets analog digital logic
// (R11) four pulled-up boot-select pins choose the boot source at start-up
// (R12) pin inputs synchronised; internal reset held while either pin reads low
package drp_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned WDG_PULSE_CYCLES = 512;
  localparam int unsigned CNT_W            = 10;

  // ==========================================================================
  // reset vectors
  localparam logic [31:0] MASTER_VECTOR_ADDR  = 32'h0000_0004;
  localparam logic [21:0] CONTROL_VECTOR_ADDR = 22'h3F_FFC0;

  // ==========================================================================
  // boot select
  localparam int unsigned  BOOT_W     = 4;
  localparam logic [3:0]   BOOT_RESET = 4'hF;

  // ==========================================================================
  // digital pin drive state
  typedef enum logic [2:0] {
    DRP_IDLE = 3'b001,
    DRP_WDG  = 3'b010,
    DRP_POR  = 3'b100
  } drp_state_t;

  // reset outputs that travel together
  typedef struct packed {
    logic dig_rst_n;
    logic ana_rst_n;
    logic boot_valid;
  } drp_rst_t;

endpackage

// File: test/drp_board_model.sv
// board side of both reset pins: internal pullups and open-drain pullers
// assumes a low enable means the device pulls its own pin low
`timescale 1ns/1ps
module drp_board_model (
  input  wire logic dig_oe_n_i,
  input  wire logic ana_oe_n_i,
  input  wire logic ext_dig_pull_i,
  input  wire logic ext_ana_pull_i,
  output logic      dig_pin_o,
  output logic      ana_pin_o
);
  // ==========================================================================
  // wired-and pins
  // nobody drives high: a released pin only returns through the pullup
  assign dig_pin_o = ~(~dig_oe_n_i | ext_dig_pull_i);
  assign ana_pin_o = ~(~ana_oe_n_i | ext_ana_pull_i);
endmodule

// File: test/drp_reset_pins_bench.sv
// self-checking bench for the dual reset pin block
// assumes drp_board_model resolves both pins; short watchdog pulse in sim
`timescale 1ns/1ps
module drp_reset_pins_bench;
  import drp_pkg::*;
  // ==========================================================================
  // signals
  localparam int unsigned PC = 8;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        dpor, apor, wdg, ext_d, ext_a, dpin, apin, d_o, a_o, d_oe_n, a_oe_n;
  logic        drst_n, arst_n, mrun, crun, bv;
  logic [3:0]  bsel, bmode;
  logic [31:0] mdat, cdat, maddr, mpc, cpc;
  logic [21:0] caddr;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #2 clock_i = ~clock_i;

  drp_reset_pins #(.PULSE_CYCLES(PC)) dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .dig_por_i(dpor), .ana_por_i(apor),
    .wdg_rst_i(wdg), .digital_reset_pin_i(dpin), .digital_reset_pin_o(d_o),
    .digital_reset_pin_oe_n_o(d_oe_n), .analog_reset_pin_i(apin),
    .analog_reset_pin_o(a_o), .analog_reset_pin_oe_n_o(a_oe_n), .boot_sel_i(bsel),
    .master_vec_data_i(mdat), .control_vec_data_i(cdat), .master_vec_addr_o(maddr),
    .control_vec_addr_o(caddr), .master_pc_o(mpc), .control_pc_o(cpc),
    .dig_rst_n_o(drst_n), .ana_rst_n_o(arst_n), .master_run_o(mrun),
    .control_run_o(crun), .boot_mode_o(bmode), .boot_valid_o(bv));

  drp_board_model board_u (
    .dig_oe_n_i(d_oe_n), .ana_oe_n_i(a_oe_n), .ext_dig_pull_i(ext_d),
    .ext_ana_pull_i(ext_a), .dig_pin_o(dpin), .ana_pin_o(apin));

  // ==========================================================================
  // shared tasks
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait until both subsystems are out of reset and running
  task automatic wait_up();
    int i;
    for (i = 0; i < 60; i++) begin
      if (drst_n === 1'b1 && arst_n === 1'b1 && mrun === 1'b1 && crun === 1'b1) begin
        return;
      end
      step(1);
    end
    chk("release", 32'h1, 32'h0);
    test_done();
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_boot();
    wait_up();
    chk("master_vec_addr", 32'h0000_0004, maddr);
    chk("control_vec_addr", 32'h003F_FFC0, 32'(caddr));
    chk("master_pc", mdat, mpc);
    chk("control_pc", cdat, cpc);
    chk("boot_mode", 32'(bsel), 32'(bmode));
    chk("boot_valid", 32'h1, 32'(bv));
    chk("dig_oe_n", 32'h1, 32'(d_oe_n));
    chk("ana_oe_n", 32'h1, 32'(a_oe_n));
    chk("dig_pin_data", 32'h0, 32'(d_o));
    chk("ana_pin_data", 32'h0, 32'(a_o));
  endtask

  task automatic t_por();
    dpor = 1'b1;
    step(3);
    chk("dig_oe_n", 32'h0, 32'(d_oe_n));
    chk("dig_rst_n", 32'h0, 32'(drst_n));
    chk("runs", 32'h0, 32'({mrun, crun}));
    dpor = 1'b0;
    wait_up();
  endtask

  task automatic t_apor();
    apor = 1'b1;
    step(3);
    chk("ana_oe_n", 32'h0, 32'(a_oe_n));
    chk("ana_rst_n", 32'h0, 32'(arst_n));
    apor = 1'b0;
    wait_up();
  endtask

  // the pin is pulled from the edge that takes the request; count from there
  task automatic t_wdg();
    int n;
    int bad;
    int r;
    n = 0;
    bad = 0;
    r = 0;
    wdg = 1'b1;
    step(1);
    wdg = 1'b0;
    repeat (40) begin
      if (d_oe_n === 1'b0) begin
        n++;
      end
      if (drst_n === 1'b0) begin
        r++;
      end
      if (drst_n === 1'b0 && (mrun !== 1'b0 || crun !== 1'b0)) begin
        bad++;
      end
      step(1);
    end
    chk("wdg_pulse_len", 32'(PC), 32'(n));
    chk("rst_in_pulse", 32'h1, 32'(r > 0));
    chk("run_in_pulse", 32'h0, 32'(bad));
    wait_up();
  endtask

  // an outside pull resets without the device pulling; new vectors load
  task automatic t_ext();
    mdat = 32'hCAFE_0100;
    cdat = 32'h0000_8A00;
    ext_d = 1'b1;
    step(4);
    chk("dig_rst_n", 32'h0, 32'(drst_n));
    chk("dig_oe_n", 32'h1, 32'(d_oe_n));
    chk("runs", 32'h0, 32'({mrun, crun}));
    ext_d = 1'b0;
    wait_up();
    chk("master_pc", 32'hCAFE_0100, mpc);
    chk("control_pc", 32'h0000_8A00, cpc);
    ext_a = 1'b1;
    step(4);
    chk("ana_rst_n", 32'h0, 32'(arst_n));
    ext_a = 1'b0;
    wait_up();
  endtask

  // reset in mid-run: both pins pulled, boot select taken again at release
  task automatic t_rst();
    bsel = 4'h5;
    rst_n_i = 1'b0;
    step(3);
    chk("rst_oe_n", 32'h0, 32'({d_oe_n, a_oe_n}));
    chk("rst_rst_n", 32'h0, 32'({drst_n, arst_n}));
    chk("rst_boot_valid", 32'h0, 32'(bv));
    chk("rst_boot_mode", 32'(BOOT_RESET), 32'(bmode));
    rst_n_i = 1'b1;
    wait_up();
    chk("boot_mode", 32'h5, 32'(bmode));
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {dpor, apor, wdg, ext_d, ext_a} = 5'h00;
    bsel = 4'hA;
    mdat = 32'h0000_1234;
    cdat = 32'h0033_0000;
    step(16);
    rst_n_i = 1'b1;
    t_boot();
    t_por();
    t_apor();
    t_wdg();
    t_ext();
    t_rst();
    test_done();
  end
endmodule
